// ===== design/status_event_if.sv
// condition and event signals shared between the top and the event set
`timescale 1ns/100ps
interface status_event_if;
    import supply_status_pkg::*;
    logic [STATUS_WIDTH-1:0] condition;  // live condition word
    logic [STATUS_WIDTH-1:0] enable;     // enable mask
    logic read_clear;                    // event register read pulse
    logic clear_all;                     // clear-status pulse
    logic [STATUS_WIDTH-1:0] event_bits; // latched events
    logic summary;                       // any enabled event
    modport owner (output condition, enable, read_clear, clear_all,
        input event_bits, summary);
    modport set (input condition, enable, read_clear, clear_all,
        output event_bits, summary);
endinterface

// ===== design/status_event_set.sv
// one status set: edge-latched event register, summary gated by an enable mask
`timescale 1ns/100ps
module status_event_set
    import supply_status_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    status_event_if.set bus
);
    logic [STATUS_WIDTH-1:0] prev_condition; // condition one cycle back
    logic [STATUS_WIDTH-1:0] event_reg;      // latched events
    wire [STATUS_WIDTH-1:0] rising;          // fixed low-to-high filter
    wire clear_now;

    assign rising = bus.condition & ~prev_condition; // filter fixed, no control input
    assign clear_now = bus.read_clear | bus.clear_all;

    // history for edge detection
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prev_condition <= STATUS_ZERO;
        end else begin
            prev_condition <= bus.condition;
        end
    end

    // an edge in the clearing cycle still lands: set beats clear
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            event_reg <= STATUS_ZERO;
        end else if (clear_now) begin
            event_reg <= rising;
        end else begin
            event_reg <= event_reg | rising;
        end
    end

    assign bus.event_bits = event_reg;
    assign bus.summary = |(event_reg & bus.enable);
endmodule

// ===== design/supply_status_and_trigger.sv
// status registers, error queue and trigger unit of the supply
`timescale 1ns/100ps
module supply_status_and_trigger
    import supply_status_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // regulation and sequencer state
    input wire logic i_cv_mode,
    input wire logic i_cc_mode,
    input wire logic i_program_running,
    // fault detectors
    input wire logic i_fault_overvoltage,
    input wire logic i_fault_overcurrent,
    input wire logic i_fault_lead,
    input wire logic i_fault_thermal,
    input wire logic i_fault_mains,
    input wire logic i_fault_fan,
    input wire logic i_fault_master_slave,
    // command interpreter side
    input wire logic i_oper_event_read,
    input wire logic i_ques_event_read,
    input wire logic i_clear_status,
    input wire logic [STATUS_WIDTH-1:0] i_oper_enable,
    input wire logic [STATUS_WIDTH-1:0] i_ques_enable,
    input wire logic i_error_push,
    input wire logic [ERR_WIDTH-1:0] i_error_code,
    input wire logic i_error_pop,
    input wire logic i_initiate,
    input wire logic i_trigger_source_select,
    input wire logic i_software_trigger,
    input wire logic i_group_execute_trigger,
    input wire logic i_voltage_trigger_preset_we,
    input wire logic i_current_trigger_preset_we,
    input wire logic [SETPOINT_WIDTH-1:0] i_preset_data,
    input wire logic i_calibrate,
    input wire logic i_model_change,
    // external trigger pin, low active
    input wire logic i_external_trigger_n,
    // readouts
    output logic [STATUS_WIDTH-1:0] o_operation_condition,
    output logic [STATUS_WIDTH-1:0] o_questionable_condition,
    output logic [STATUS_WIDTH-1:0] o_operation_event,
    output logic [STATUS_WIDTH-1:0] o_questionable_event,
    output logic [STB_WIDTH-1:0] o_status_summary,
    output logic [ERR_WIDTH-1:0] o_error_head,
    output logic o_error_queue_not_empty,
    output logic [SETPOINT_WIDTH-1:0] o_voltage_setpoint,
    output logic [SETPOINT_WIDTH-1:0] o_current_setpoint,
    output logic [SETPOINT_WIDTH-1:0] o_voltage_trigger_preset,
    output logic [SETPOINT_WIDTH-1:0] o_current_trigger_preset,
    output logic o_trigger_fired
);
    status_event_if oper_if ();  // operation set wiring
    status_event_if ques_if ();  // questionable set wiring

    // ---------------- trigger section ----------------
    logic ext_sync_a;           // first stage, only feeds ext_sync_b
    logic ext_sync_b;           // settled line level
    logic ext_prev;             // previous settled level
    arm_state_t arm_state;      // armed or idle
    arm_state_t next_arm_state;
    wire ext_fall;              // one pulse per falling edge
    wire sw_trig;               // software trigger request
    wire trig_event;            // accepted trigger from selected source
    wire fire;                  // trigger while armed
    wire preset_reset;          // presets back to minimum
    wire waiting;

    // two-flop synchroniser, reset high so the idle line is not a fall
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ext_sync_a <= 1'b1;
            ext_sync_b <= 1'b1;
            ext_prev <= 1'b1;
        end else begin
            ext_sync_a <= i_external_trigger_n;
            ext_sync_b <= ext_sync_a;
            ext_prev <= ext_sync_b;
        end
    end

    assign ext_fall = ext_prev & ~ext_sync_b; // grounded line acts once
    assign sw_trig = i_software_trigger | i_group_execute_trigger;
    // only the selected source counts; the other is ignored
    assign trig_event = (i_trigger_source_select == SRC_HARDWARE) ? ext_fall : sw_trig;
    assign waiting = (arm_state == ARM_WAIT);
    assign fire = waiting & trig_event;
    assign preset_reset = i_calibrate | i_model_change;

    // arm machine: initiate arms, trigger disarms
    always_comb begin
        next_arm_state = arm_state;
        case (arm_state)
            ARM_IDLE: begin
                if (i_initiate) begin
                    next_arm_state = ARM_WAIT;
                end
            end
            ARM_WAIT: begin
                if (fire) begin
                    next_arm_state = ARM_IDLE; // same edge as setpoint load
                end
            end
            default: begin
                next_arm_state = ARM_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            arm_state <= ARM_IDLE;
        end else begin
            arm_state <= next_arm_state;
        end
    end

    // preset storage; reset request wins over a write in the same cycle
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_voltage_trigger_preset <= VOLT_PRESET_MIN;
            o_current_trigger_preset <= CURR_PRESET_MIN;
        end else if (preset_reset) begin
            o_voltage_trigger_preset <= VOLT_PRESET_MIN;
            o_current_trigger_preset <= CURR_PRESET_MIN;
        end else begin
            if (i_voltage_trigger_preset_we) begin
                o_voltage_trigger_preset <= i_preset_data;
            end
            if (i_current_trigger_preset_we) begin
                o_current_trigger_preset <= i_preset_data;
            end
        end
    end

    // setpoints take the presets on an accepted trigger
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_voltage_setpoint <= VOLT_PRESET_MIN;
            o_current_setpoint <= CURR_PRESET_MIN;
            o_trigger_fired <= 1'b0;
        end else begin
            o_trigger_fired <= fire;
            if (fire) begin
                o_voltage_setpoint <= o_voltage_trigger_preset;
                o_current_setpoint <= o_current_trigger_preset;
            end
        end
    end

    // ---------------- condition words ----------------
    logic [STATUS_WIDTH-1:0] oper_cond; // live operation word
    logic [STATUS_WIDTH-1:0] ques_cond; // live questionable word

    // unused bits fall out as zero from the default
    always_comb begin
        oper_cond = STATUS_ZERO;
        oper_cond[OPER_WAIT_TRIG_BIT] = waiting;
        oper_cond[OPER_CV_BIT] = i_cv_mode;
        oper_cond[OPER_CC_BIT] = i_cc_mode;
        oper_cond[OPER_PROG_RUN_BIT] = i_program_running;
        ques_cond = STATUS_ZERO;
        ques_cond[QUES_OV_BIT] = i_fault_overvoltage;
        ques_cond[QUES_OC_BIT] = i_fault_overcurrent;
        ques_cond[QUES_LEAD_BIT] = i_fault_lead;
        ques_cond[QUES_THERMAL_BIT] = i_fault_thermal;
        ques_cond[QUES_MAINS_BIT] = i_fault_mains;
        ques_cond[QUES_FAN_BIT] = i_fault_fan;
        ques_cond[QUES_MS_BIT] = i_fault_master_slave;
    end

    assign oper_if.condition = oper_cond;
    assign oper_if.enable = i_oper_enable;
    assign oper_if.read_clear = i_oper_event_read;
    assign oper_if.clear_all = i_clear_status;
    assign ques_if.condition = ques_cond;
    assign ques_if.enable = i_ques_enable;
    assign ques_if.read_clear = i_ques_event_read;
    assign ques_if.clear_all = i_clear_status;

    // operation set
    status_event_set u_oper_set (
        .i_core_clk (i_core_clk),
        .i_arst_n (i_arst_n),
        .bus (oper_if)
    );

    // questionable set
    status_event_set u_ques_set (
        .i_core_clk (i_core_clk),
        .i_arst_n (i_arst_n),
        .bus (ques_if)
    );

    // registered readouts; condition words follow inputs one cycle late
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_operation_condition <= STATUS_ZERO;
            o_questionable_condition <= STATUS_ZERO;
            o_operation_event <= STATUS_ZERO;
            o_questionable_event <= STATUS_ZERO;
            o_status_summary <= '0;
        end else begin
            o_operation_condition <= oper_cond;
            o_questionable_condition <= ques_cond;
            o_operation_event <= oper_if.event_bits;
            o_questionable_event <= ques_if.event_bits;
            o_status_summary <= '0;
            o_status_summary[STB_QUES_BIT] <= ques_if.summary;
            o_status_summary[STB_OPER_BIT] <= oper_if.summary;
        end
    end

    // ---------------- error queue ----------------
    // circular buffer; full means 15 stored, the last slot may be -350
    logic [ERR_WIDTH-1:0] err_mem [ERR_DEPTH];
    logic [ERR_PTR_WIDTH-1:0] rd_ptr;
    logic [ERR_PTR_WIDTH-1:0] wr_ptr;
    logic [ERR_PTR_WIDTH:0] err_count;
    logic overflowed;           // overflow marker already written
    wire do_pop;
    wire has_room;
    wire do_store;
    wire mark_overflow;
    wire [ERR_PTR_WIDTH-1:0] last_slot;
    wire [ERR_PTR_WIDTH-1:0] rd_next;
    wire [ERR_PTR_WIDTH-1:0] wr_next;

    assign do_pop = i_error_pop & (err_count != '0);
    // last free slot is held back for the overflow marker
    // a pop in the same cycle frees a slot, so the push is not lost unmarked
    assign has_room = ((err_count + COUNT_ONE) < COUNT_FULL) | (do_pop & ~overflowed);
    assign do_store = i_error_push & has_room;
    // arrival with only the final slot left: keep old, mark overflow
    assign mark_overflow = i_error_push & ~has_room & ~overflowed & ~do_pop;
    assign rd_next = (rd_ptr == PTR_LAST) ? PTR_ZERO : rd_ptr + PTR_ONE;
    assign wr_next = (wr_ptr == PTR_LAST) ? PTR_ZERO : wr_ptr + PTR_ONE;
    assign last_slot = wr_ptr;

    // storage write
    always_ff @(posedge i_core_clk) begin
        if (do_store) begin
            err_mem[wr_ptr] <= i_error_code;
        end else if (mark_overflow) begin
            err_mem[last_slot] <= ERR_TOO_MANY;
        end
    end

    // pointers and occupancy
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_ptr <= PTR_ZERO;
            wr_ptr <= PTR_ZERO;
            err_count <= '0;
            overflowed <= 1'b0;
        end else begin
            if (do_pop) begin
                rd_ptr <= rd_next;
            end
            if (do_store | mark_overflow) begin
                wr_ptr <= wr_next;
            end
            err_count <= err_count + {4'h0, (do_store | mark_overflow)} - {4'h0, do_pop};
            if (mark_overflow) begin
                overflowed <= 1'b1;
            end else if (do_pop) begin
                overflowed <= 1'b0; // room again once an entry leaves
            end
        end
    end

    // head of queue shown as a register, code zero when empty
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_error_head <= ERR_NONE;
            o_error_queue_not_empty <= 1'b0;
        end else begin
            o_error_head <= (err_count == '0) ? ERR_NONE : err_mem[rd_ptr];
            o_error_queue_not_empty <= (err_count != '0);
        end
    end
endmodule

// ===== design/supply_status_pkg.sv
// shared constants for the supply status and trigger block
package supply_status_pkg;
    localparam int STATUS_WIDTH = 16;       // condition and event register width
    localparam int SETPOINT_WIDTH = 16;     // voltage and current code width
    localparam int ERR_WIDTH = 16;          // signed error code width
    localparam int ERR_DEPTH = 15;          // error queue capacity
    localparam int ERR_PTR_WIDTH = 4;       // queue index width
    // operation condition bit positions
    localparam int OPER_WAIT_TRIG_BIT = 5;
    localparam int OPER_CV_BIT = 8;
    localparam int OPER_CC_BIT = 10;
    localparam int OPER_PROG_RUN_BIT = 14;
    // questionable condition bit positions
    localparam int QUES_OV_BIT = 0;
    localparam int QUES_OC_BIT = 1;
    localparam int QUES_LEAD_BIT = 2;
    localparam int QUES_THERMAL_BIT = 3;
    localparam int QUES_MAINS_BIT = 4;
    localparam int QUES_FAN_BIT = 5;
    localparam int QUES_MS_BIT = 6;
    localparam int QUES_FAULT_COUNT = 7;    // bits 7..15 unused
    // status byte summary positions
    localparam int STB_QUES_BIT = 3;
    localparam int STB_OPER_BIT = 7;
    localparam int STB_WIDTH = 8;
    // error codes
    localparam logic [ERR_WIDTH-1:0] ERR_NONE = 16'h0000;          // 0, no error
    localparam logic [ERR_WIDTH-1:0] ERR_TOO_MANY = 16'hFEA2;      // -350
    // preset defaults after calibration or model change
    localparam logic [SETPOINT_WIDTH-1:0] VOLT_PRESET_MIN = 16'h0000;
    localparam logic [SETPOINT_WIDTH-1:0] CURR_PRESET_MIN = 16'h0000;
    localparam logic [STATUS_WIDTH-1:0] STATUS_ZERO = 16'h0000;
    localparam logic [ERR_PTR_WIDTH-1:0] PTR_ZERO = 4'h0;
    localparam logic [ERR_PTR_WIDTH-1:0] PTR_ONE = 4'h1;
    localparam logic [ERR_PTR_WIDTH-1:0] PTR_LAST = 4'hE;          // depth minus one
    localparam logic [ERR_PTR_WIDTH:0] COUNT_FULL = 5'h0F;
    localparam logic [ERR_PTR_WIDTH:0] COUNT_ONE = 5'h01;
    // trigger source selection
    typedef enum logic {SRC_SOFTWARE = 1'b0, SRC_HARDWARE = 1'b1} trig_src_t;
    // arm state machine, one-hot
    typedef enum logic [1:0] {ARM_IDLE = 2'b01, ARM_WAIT = 2'b10} arm_state_t;
endpackage

// ===== verification/supply_status_props.sv
// concurrent checks on the status, error queue and trigger ports
`timescale 1ns/100ps
module supply_status_props
    import supply_status_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic [STATUS_WIDTH-1:0] i_ques_enable,
    input wire logic i_initiate,
    input wire logic i_trigger_source_select,
    input wire logic i_software_trigger,
    input wire logic i_calibrate,
    input wire logic i_model_change,
    input wire logic [STATUS_WIDTH-1:0] o_operation_condition,
    input wire logic [STATUS_WIDTH-1:0] o_questionable_condition,
    input wire logic [STATUS_WIDTH-1:0] o_questionable_event,
    input wire logic [STB_WIDTH-1:0] o_status_summary,
    input wire logic [ERR_WIDTH-1:0] o_error_head,
    input wire logic o_error_queue_not_empty,
    input wire logic [SETPOINT_WIDTH-1:0] o_voltage_setpoint,
    input wire logic [SETPOINT_WIDTH-1:0] o_voltage_trigger_preset,
    input wire logic o_trigger_fired
);
    logic [STATUS_WIDTH-1:0] prev_ques; // condition word one cycle back
    logic [STATUS_WIDTH-1:0] ques_rise; // bits that just went high
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // delayed copy kept in helper logic so no $past nests inside another
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prev_ques <= STATUS_ZERO;
        end else begin
            prev_ques <= o_questionable_condition;
        end
    end
    assign ques_rise = o_questionable_condition & ~prev_ques;
    a_oper_unused_zero: assert property ((o_operation_condition & 16'hBADF) == 16'h0000)
        else $error("unused operation condition bit set");
    a_ques_unused_zero: assert property (
        (o_questionable_condition & 16'hFF80) == 16'h0000)
        else $error("unused questionable condition bit set");
    a_event_latches_rise: assert property ((ques_rise != 16'h0000) |=>
        ((o_questionable_event & $past(ques_rise)) == $past(ques_rise)))
        else $error("rising condition bit not latched as event");
    a_ques_summary: assert property ($stable(i_ques_enable) |->
        (o_status_summary[STB_QUES_BIT] == |(o_questionable_event & i_ques_enable)))
        else $error("questionable summary bit disagrees with enabled events");
    a_stb_unused_zero: assert property ((o_status_summary & 8'h77) == 8'h00)
        else $error("summary byte bit other than 3 or 7 set");
    a_soft_trig_load: assert property ((o_operation_condition[OPER_WAIT_TRIG_BIT]
        && !o_trigger_fired && !i_trigger_source_select && i_software_trigger) |=>
        (o_trigger_fired && (o_voltage_setpoint == $past(o_voltage_trigger_preset))))
        else $error("armed software trigger did not load the preset");
    a_wait_flag_drop: assert property ((o_trigger_fired && !i_initiate) |=>
        !o_operation_condition[OPER_WAIT_TRIG_BIT])
        else $error("waiting flag still set after trigger");
    a_single_fire: assert property (o_trigger_fired |=> !o_trigger_fired)
        else $error("trigger fired on two cycles in a row");
    // the flag shown beside the pulse is the state the trigger met; an arm
    // just before the trigger is legal, so no look further back
    a_fire_only_armed: assert property (o_trigger_fired |->
        o_operation_condition[OPER_WAIT_TRIG_BIT])
        else $error("trigger fired while not armed");
    a_preset_default: assert property ((i_calibrate || i_model_change) |=>
        (o_voltage_trigger_preset == VOLT_PRESET_MIN))
        else $error("voltage preset not returned to minimum");
    a_empty_no_error: assert property (!o_error_queue_not_empty |->
        (o_error_head == ERR_NONE))
        else $error("empty error queue shows a code other than zero");
endmodule

// ===== verification/tb_supply_status_and_trigger.sv
// self-checking bench for the status, error queue and trigger block
`timescale 1ns/100ps
module tb_supply_status_and_trigger;
    import supply_status_pkg::*;
    // strobe indices into cmd
    localparam int ORD = 0, QRD = 1, CLR = 2, PSH = 3, POP = 4, INI = 5, SWT = 6, GET = 7;
    localparam int VWE = 8, CWE = 9, CAL = 10, MDL = 11, HWQ = 12;
    logic i_core_clk = 1'b0, i_arst_n = 1'b0, src = 1'b0, line_n;
    logic [12:0] cmd = 13'h0000; // command strobes, one cycle each; the push strobe is held twenty cycles
    logic [9:0] cond_in = 10'h000; // prog, cc, cv, then seven faults
    logic [15:0] oper_en = 16'h0000, ques_en = 16'h0000, code = 16'h0000, pdata = 16'h0000;
    logic [15:0] ocond, qcond, oevt, qevt, head, vset, cset, vpre, cpre;
    logic [7:0] summ;
    logic not_empty, fired;
    logic [15:0] exp_head; // expected head of the error queue
    int err_count = 0, n_tests = 0, cycles = 0;
    // level table: inputs, expected operation word, expected questionable word
    logic [41:0] rows [11] = '{{10'h001, 16'h0000, 16'h0001}, {10'h002, 16'h0000, 16'h0002},
        {10'h004, 16'h0000, 16'h0004}, {10'h008, 16'h0000, 16'h0008},
        {10'h010, 16'h0000, 16'h0010}, {10'h020, 16'h0000, 16'h0020},
        {10'h040, 16'h0000, 16'h0040}, {10'h080, 16'h0100, 16'h0000},
        {10'h100, 16'h0400, 16'h0000}, {10'h200, 16'h4000, 16'h0000},
        {10'h3FF, 16'h4500, 16'h007F}};
    always #2 i_core_clk = ~i_core_clk;
    supply_status_and_trigger i_dut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
        .i_cv_mode(cond_in[7]), .i_cc_mode(cond_in[8]), .i_program_running(cond_in[9]),
        .i_fault_overvoltage(cond_in[0]), .i_fault_overcurrent(cond_in[1]),
        .i_fault_lead(cond_in[2]), .i_fault_thermal(cond_in[3]), .i_fault_mains(cond_in[4]),
        .i_fault_fan(cond_in[5]), .i_fault_master_slave(cond_in[6]),
        .i_oper_event_read(cmd[ORD]), .i_ques_event_read(cmd[QRD]), .i_clear_status(cmd[CLR]),
        .i_oper_enable(oper_en), .i_ques_enable(ques_en), .i_error_push(cmd[PSH]),
        .i_error_code(code), .i_error_pop(cmd[POP]), .i_initiate(cmd[INI]),
        .i_trigger_source_select(src), .i_software_trigger(cmd[SWT]),
        .i_group_execute_trigger(cmd[GET]), .i_voltage_trigger_preset_we(cmd[VWE]),
        .i_current_trigger_preset_we(cmd[CWE]), .i_preset_data(pdata),
        .i_calibrate(cmd[CAL]), .i_model_change(cmd[MDL]), .i_external_trigger_n(line_n),
        .o_operation_condition(ocond), .o_questionable_condition(qcond),
        .o_operation_event(oevt), .o_questionable_event(qevt), .o_status_summary(summ),
        .o_error_head(head), .o_error_queue_not_empty(not_empty), .o_voltage_setpoint(vset),
        .o_current_setpoint(cset), .o_voltage_trigger_preset(vpre),
        .o_current_trigger_preset(cpre), .o_trigger_fired(fired));
    trigger_line_party i_party (.i_core_clk(i_core_clk), .i_request(cmd[HWQ]),
        .o_external_trigger_n(line_n));
    // compare one value, report and count a mismatch
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // wait n rising edges, then let that edge's updates settle
    task automatic step(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    // one-cycle strobe, launched and dropped on rising edges
    task automatic strobe(input int k);
        @(posedge i_core_clk) cmd[k] <= 1'b1;
        @(posedge i_core_clk) cmd[k] <= 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        step(6);
        check(ocond, 16'h0000);
        check(head, ERR_NONE);
        check(vset, 16'h0000);
        repeat (6) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        // live condition words, one row per condition, then one row with all set
        foreach (rows[i]) begin
            @(posedge i_core_clk) cond_in <= rows[i][41:32];
            step(3);
            check(ocond, rows[i][31:16]);
            check(qcond, rows[i][15:0]);
        end
        @(posedge i_core_clk) cond_in <= 10'h000;
        step(3);
        check(qcond, 16'h0000);
        strobe(CLR);
        step(3);
        check(qevt, 16'h0000);
        check(oevt, 16'h0000);
        @(posedge i_core_clk) cond_in <= 10'h001;
        step(3);
        check(qevt, 16'h0001);
        check({8'h00, summ}, 16'h0000);
        @(posedge i_core_clk) ques_en <= 16'h0001;
        step(3);
        check({8'h00, summ}, 16'h0008);
        strobe(QRD);
        step(3);
        check(qevt, 16'h0000);
        check({8'h00, summ}, 16'h0000);
        // a falling condition must leave no event behind
        @(posedge i_core_clk) cond_in <= 10'h000;
        step(3);
        check(qevt, 16'h0000);
        @(posedge i_core_clk) oper_en <= 16'h0100;
        cond_in <= 10'h080;
        step(3);
        check(oevt, 16'h0100);
        check({8'h00, summ}, 16'h0080);
        strobe(ORD);
        step(3);
        check(oevt, 16'h0000);
        // error queue: empty read, then twenty back-to-back pushes
        check(head, ERR_NONE);
        for (int i = 1; i <= 20; i++) begin
            @(posedge i_core_clk) cmd[PSH] <= 1'b1;
            code <= 16'(i);
        end
        @(posedge i_core_clk) cmd[PSH] <= 1'b0;
        for (int k = 1; k <= 16; k++) begin
            step(3);
            exp_head = (k < 15) ? 16'(k) : (k == 15) ? ERR_TOO_MANY : ERR_NONE;
            check(head, exp_head);
            strobe(POP);
        end
        step(3);
        check({15'h0000, not_empty}, 16'h0000);
        // presets, then a software-armed trigger
        @(posedge i_core_clk) cmd[VWE] <= 1'b1;
        pdata <= 16'h1234;
        @(posedge i_core_clk) cmd[VWE] <= 1'b0;
        cmd[CWE] <= 1'b1;
        pdata <= 16'h0567;
        @(posedge i_core_clk) cmd[CWE] <= 1'b0;
        strobe(INI);
        step(3);
        check(ocond & 16'h0020, 16'h0020);
        strobe(HWQ);
        step(8);
        check(vset, 16'h0000);
        strobe(SWT);
        step(3);
        check(vset, 16'h1234);
        check(cset, 16'h0567);
        check(ocond & 16'h0020, 16'h0000);
        @(posedge i_core_clk) cmd[VWE] <= 1'b1;
        pdata <= 16'h0ABC;
        @(posedge i_core_clk) cmd[VWE] <= 1'b0;
        strobe(INI);
        step(3);
        strobe(GET);
        step(3);
        check(vset, 16'h0ABC);
        // hardware source: commands refused, grounded line accepted
        @(posedge i_core_clk) src <= 1'b1;
        cmd[VWE] <= 1'b1;
        pdata <= 16'h0F0F;
        @(posedge i_core_clk) cmd[VWE] <= 1'b0;
        strobe(INI);
        step(3);
        strobe(SWT);
        step(3);
        check(vset, 16'h0ABC);
        strobe(HWQ);
        step(8);
        check(vset, 16'h0F0F);
        check(ocond & 16'h0020, 16'h0000);
        strobe(CAL);
        step(3);
        check(vpre, VOLT_PRESET_MIN);
        check(cpre, CURR_PRESET_MIN);
        @(posedge i_core_clk) cmd[VWE] <= 1'b1;
        pdata <= 16'h0001;
        @(posedge i_core_clk) cmd[VWE] <= 1'b0;
        strobe(MDL);
        step(3);
        check(vpre, VOLT_PRESET_MIN);
        // reset again mid-run: setpoints fall back, live conditions return
        @(posedge i_core_clk) i_arst_n <= 1'b0;
        step(2);
        check(vset, 16'h0000);
        check(cset, 16'h0000);
        @(posedge i_core_clk) i_arst_n <= 1'b1;
        step(3);
        check(ocond, 16'h0100);
        check(oevt, 16'h0100);
        check({8'h00, summ}, 16'h0080);
        finish_test();
    end
endmodule
bind supply_status_and_trigger supply_status_props i_props (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_ques_enable(i_ques_enable), .i_initiate(i_initiate),
    .i_trigger_source_select(i_trigger_source_select), .i_software_trigger(i_software_trigger),
    .i_calibrate(i_calibrate), .i_model_change(i_model_change),
    .o_operation_condition(o_operation_condition),
    .o_questionable_condition(o_questionable_condition),
    .o_questionable_event(o_questionable_event), .o_status_summary(o_status_summary),
    .o_error_head(o_error_head), .o_error_queue_not_empty(o_error_queue_not_empty),
    .o_voltage_setpoint(o_voltage_setpoint), .o_voltage_trigger_preset(o_voltage_trigger_preset),
    .o_trigger_fired(o_trigger_fired));

// ===== verification/trigger_line_party.sv
// far-side party that grounds the external trigger line on request
`timescale 1ns/100ps
module trigger_line_party
(
    input wire logic i_core_clk,
    input wire logic i_request,
    output logic o_external_trigger_n
);
    logic [2:0] low_left = 3'h0; // cycles of grounding still to go
    // the party drives the line low for four cycles, then drives it high again when released
    always_ff @(posedge i_core_clk) begin
        if (i_request && low_left == 3'h0) begin
            low_left <= 3'h4;
        end else if (low_left != 3'h0) begin
            low_left <= low_left - 3'h1;
        end
    end
    assign o_external_trigger_n = (low_left == 3'h0);
endmodule
